// *** rtl/gpio_cmd_pkg.sv ***
// shared constants for the command-driven general purpose line port
package gpio_cmd_pkg;

	// register byte offsets
	localparam logic [7:0] DIR_OFFSET = 8'h00;
	localparam logic [7:0] CMD_OFFSET = 8'h04;
	localparam logic [7:0] SET_ALL_OFFSET = 8'h08;
	localparam logic [7:0] RST_REPORT_OFFSET = 8'h0C;
	localparam logic [7:0] LINE_STATE_OFFSET = 8'h10;
	localparam logic [7:0] QUERY_OFFSET = 8'h14;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h18;
	localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h1C;
	localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h20;
	localparam logic [7:0] SAVE_OFFSET = 8'h24;

	// command register field layout
	localparam int CMD_LINE_LSB = 0;
	localparam int CMD_LINE_MSB = 7;
	localparam int CMD_OP_LSB = 8;
	localparam int CMD_OP_MSB = 11;
	localparam int CMD_VALUE_LSB = 16;
	localparam int CMD_VALUE_MSB = 31;

	// report register field layout
	localparam int REPORT_INPUT_LSB = 16;
	localparam int QUERY_VALID_BIT = 8;

	// interrupt status bit positions
	localparam int IRQ_ERR_BIT = 0;
	localparam int IRQ_SAVE_BIT = 1;
	localparam int IRQ_BITS = 2;

	// reset values
	localparam logic [15:0] DIR_RESET = 16'h0000;
	localparam logic [15:0] RST_STATE_FACTORY = 16'hFFFF;
	localparam logic [15:0] OUT_RESET = 16'hFFFF;
	localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// command opcodes written to the command register
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_DRIVE_HIGH = 4'h1,
		OP_DRIVE_LOW = 4'h2,
		OP_SET_RESET_STATE = 4'h3,
		OP_QUERY_RESET_STATE = 4'h4
	} cmd_op_t;

endpackage

// *** rtl/gpio_command_port.sv ***
// general purpose line port with direction mask, line commands and reset states
`timescale 1ns/100ps
// Behaviour
// - sixteen-bit direction mask, one means output
// - drive-high command sets chosen output high
// - drive-low command sets chosen output low
// - outputs go high after reset unless redefined
// - drive commands to input lines change nothing
// - reset-state command on non-output flags error
// - nonzero reset value records high, zero low
// - full report: states plus input dash marks
// - single-line query answers zero or one
// - reset-state command executes immediately, unqueued
// - reset-state changes stored to nonvolatile automatically
// - reset-state command accepted in every axis mode
// - save command stores direction mask too
// - new output starts at its reset state
// - factory reset state is high everywhere
module gpio_command_port #(
	parameter int LINES = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// general purpose line pins
	input wire logic [15:0] gpio_in,
	output logic [15:0] gpio_out,
	output logic [15:0] gpio_oe,
	// nonvolatile parameter store
	output logic nv_store,
	output logic [15:0] nv_store_dir,
	output logic [15:0] nv_store_rst_state,
	input wire logic nv_load,
	input wire logic [15:0] nv_load_dir,
	input wire logic [15:0] nv_load_rst_state,
	// interrupt
	output logic irq
);

	// elaboration-time check: the pin and register layout is fixed at sixteen lines
	if (LINES != 16) begin
		$error("gpio_command_port supports exactly 16 lines");
	end

	// pin synchroniser, first stage read only by the second
	logic [15:0] pin_meta;
	logic [15:0] pin_sync;

	always_ff @(posedge clk) begin
		pin_meta <= gpio_in;
		pin_sync <= pin_meta;
	end

	// bus handshake state
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready;
	logic next_rvalid;
	logic [1:0] next_rresp;
	logic [31:0] next_rdata;
	logic wr_fire;
	logic rd_fire;
	logic wr_full;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_word;

	// port state
	logic [15:0] dir;
	logic [15:0] rst_state;
	logic [15:0] out_level;
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	logic query_valid;
	logic query_value;
	logic [15:0] next_dir;
	logic [15:0] next_rst_state;
	logic [15:0] next_out_level;
	logic [1:0] next_irq_status;
	logic [1:0] next_irq_enable;
	logic next_query_valid;
	logic next_query_value;
	logic next_nv_store;
	logic next_irq;

	assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	// commands act only on full-word writes so no half command is ever issued
	assign wr_full = (s_axi_wstrb == 4'hF);

	// write address decode
	always_comb begin
		if (s_axi_awaddr == gpio_cmd_pkg::DIR_OFFSET) begin
			wr_hit = 1'b1;
		end else if (s_axi_awaddr == gpio_cmd_pkg::CMD_OFFSET) begin
			wr_hit = 1'b1;
		end else if (s_axi_awaddr == gpio_cmd_pkg::SET_ALL_OFFSET) begin
			wr_hit = 1'b1;
		end else if (s_axi_awaddr == gpio_cmd_pkg::IRQ_CLEAR_OFFSET) begin
			wr_hit = 1'b1;
		end else if (s_axi_awaddr == gpio_cmd_pkg::IRQ_ENABLE_OFFSET) begin
			wr_hit = 1'b1;
		end else if (s_axi_awaddr == gpio_cmd_pkg::SAVE_OFFSET) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	// read mux; the report puts a one in the upper half for each input line
	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		if (s_axi_araddr == gpio_cmd_pkg::DIR_OFFSET) begin
			rd_word[15:0] = dir;
		end else if (s_axi_araddr == gpio_cmd_pkg::RST_REPORT_OFFSET) begin
			rd_word[15:0] = rst_state & dir;
			rd_word[gpio_cmd_pkg::REPORT_INPUT_LSB +: 16] = ~dir;
		end else if (s_axi_araddr == gpio_cmd_pkg::LINE_STATE_OFFSET) begin
			rd_word[15:0] = (pin_sync & ~dir) | (out_level & dir);
		end else if (s_axi_araddr == gpio_cmd_pkg::QUERY_OFFSET) begin
			rd_word[0] = query_value;
			rd_word[gpio_cmd_pkg::QUERY_VALID_BIT] = query_valid;
		end else if (s_axi_araddr == gpio_cmd_pkg::IRQ_STATUS_OFFSET) begin
			rd_word[1:0] = irq_status;
		end else if (s_axi_araddr == gpio_cmd_pkg::IRQ_ENABLE_OFFSET) begin
			rd_word[1:0] = irq_enable;
		end else if (s_axi_araddr == gpio_cmd_pkg::CMD_OFFSET) begin
			rd_word = 32'h0000_0000;
		end else if (s_axi_araddr == gpio_cmd_pkg::SET_ALL_OFFSET) begin
			rd_word[15:0] = out_level;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// axi4-lite handshakes: address and data taken together, one cycle later
	always_comb begin
		next_awready = 1'b0;
		next_wready = 1'b0;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_arready = 1'b0;
		next_rvalid = s_axi_rvalid;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
			next_awready = 1'b1;
			next_wready = 1'b1;
		end
		if (wr_fire) begin
			next_bvalid = 1'b1;
			next_bresp = wr_hit ? gpio_cmd_pkg::RESP_OKAY : gpio_cmd_pkg::RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
			next_arready = 1'b1;
		end
		if (rd_fire) begin
			next_rvalid = 1'b1;
			next_rdata = rd_hit ? rd_word : 32'h0000_0000;
			next_rresp = rd_hit ? gpio_cmd_pkg::RESP_OKAY : gpio_cmd_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= gpio_cmd_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= gpio_cmd_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
		end
	end

	// command execution; every command acts in the cycle it is written, unless a load in that same cycle wins over it
	always_comb begin
		logic [7:0] line;
		logic [3:0] op;
		logic [15:0] value;
		logic [15:0] line_bit;
		logic [15:0] new_out;
		logic err;
		logic store;
		logic [1:0] clr;
		line = s_axi_wdata[gpio_cmd_pkg::CMD_LINE_MSB:gpio_cmd_pkg::CMD_LINE_LSB];
		op = s_axi_wdata[gpio_cmd_pkg::CMD_OP_MSB:gpio_cmd_pkg::CMD_OP_LSB];
		value = s_axi_wdata[gpio_cmd_pkg::CMD_VALUE_MSB:gpio_cmd_pkg::CMD_VALUE_LSB];
		line_bit = 16'h0001 << line[3:0];
		new_out = 16'h0000;
		err = 1'b0;
		store = 1'b0;
		clr = 2'h0;
		next_dir = dir;
		next_rst_state = rst_state;
		next_out_level = out_level;
		next_irq_enable = irq_enable;
		next_query_valid = query_valid;
		next_query_value = query_value;
		if (nv_load) begin
			// restored parameters: outputs settle at the stored reset state
			next_dir = nv_load_dir;
			next_rst_state = nv_load_rst_state;
			next_out_level = nv_load_rst_state;
		end else if (wr_fire) begin
			if (s_axi_awaddr == gpio_cmd_pkg::DIR_OFFSET) begin
				// per byte lane, any value 0000..FFFF accepted
				if (s_axi_wstrb[0]) begin
					next_dir[7:0] = s_axi_wdata[7:0];
				end
				if (s_axi_wstrb[1]) begin
					next_dir[15:8] = s_axi_wdata[15:8];
				end
				new_out = next_dir & ~dir;
				next_out_level = (out_level & ~new_out) | (rst_state & new_out);
			end else if (s_axi_awaddr == gpio_cmd_pkg::CMD_OFFSET && wr_full) begin
				// no queue and no mode check: accepted in every axis mode
				if (line > 8'h0F && op != gpio_cmd_pkg::OP_NONE) begin
					err = 1'b1;
				end else if (op == gpio_cmd_pkg::OP_DRIVE_HIGH) begin
					next_out_level = out_level | (line_bit & dir);
				end else if (op == gpio_cmd_pkg::OP_DRIVE_LOW) begin
					next_out_level = out_level & ~(line_bit & dir);
				end else if (op == gpio_cmd_pkg::OP_SET_RESET_STATE) begin
					if ((dir & line_bit) == 16'h0000) begin
						err = 1'b1;
					end else begin
						if (value != 16'h0000) begin
							next_rst_state = rst_state | line_bit;
						end else begin
							next_rst_state = rst_state & ~line_bit;
						end
						store = 1'b1;
					end
				end else if (op == gpio_cmd_pkg::OP_QUERY_RESET_STATE) begin
					if ((dir & line_bit) == 16'h0000) begin
						err = 1'b1;
						next_query_valid = 1'b0;
					end else begin
						next_query_valid = 1'b1;
						next_query_value = |(rst_state & line_bit);
					end
				end else if (op != gpio_cmd_pkg::OP_NONE) begin
					err = 1'b1;
				end
			end else if (s_axi_awaddr == gpio_cmd_pkg::SET_ALL_OFFSET && wr_full) begin
				// data aimed at input lines has no effect
				next_out_level = (out_level & ~dir) | (s_axi_wdata[15:0] & dir);
			end else if (s_axi_awaddr == gpio_cmd_pkg::IRQ_CLEAR_OFFSET && s_axi_wstrb[0]) begin
				clr = s_axi_wdata[1:0];
			end else if (s_axi_awaddr == gpio_cmd_pkg::IRQ_ENABLE_OFFSET && s_axi_wstrb[0]) begin
				next_irq_enable = s_axi_wdata[1:0];
			end else if (s_axi_awaddr == gpio_cmd_pkg::SAVE_OFFSET && wr_full) begin
				store = 1'b1;
			end
		end
		next_nv_store = store;
		// set wins over a clear in the same cycle
		next_irq_status = irq_status & ~clr;
		next_irq_status[gpio_cmd_pkg::IRQ_ERR_BIT] = next_irq_status[gpio_cmd_pkg::IRQ_ERR_BIT] | err;
		next_irq_status[gpio_cmd_pkg::IRQ_SAVE_BIT] = next_irq_status[gpio_cmd_pkg::IRQ_SAVE_BIT] | store;
		next_irq = |(next_irq_status & next_irq_enable);
	end

	// store snapshot uses the post-command values so the archive is current
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dir <= gpio_cmd_pkg::DIR_RESET;
			rst_state <= gpio_cmd_pkg::RST_STATE_FACTORY;
			out_level <= gpio_cmd_pkg::OUT_RESET;
			irq_status <= 2'h0;
			irq_enable <= gpio_cmd_pkg::IRQ_ENABLE_RESET;
			query_valid <= 1'b0;
			query_value <= 1'b0;
			nv_store <= 1'b0;
			nv_store_dir <= gpio_cmd_pkg::DIR_RESET;
			nv_store_rst_state <= gpio_cmd_pkg::RST_STATE_FACTORY;
			irq <= 1'b0;
		end else begin
			dir <= next_dir;
			rst_state <= next_rst_state;
			out_level <= next_out_level;
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			query_valid <= next_query_valid;
			query_value <= next_query_value;
			nv_store <= next_nv_store;
			nv_store_dir <= next_dir;
			nv_store_rst_state <= next_rst_state;
			irq <= next_irq;
		end
	end

	// pin drivers; input lines are released, not driven
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gpio_out <= gpio_cmd_pkg::OUT_RESET;
			gpio_oe <= gpio_cmd_pkg::DIR_RESET;
		end else begin
			gpio_out <= next_out_level;
			gpio_oe <= next_dir;
		end
	end

endmodule

// *** tb/gpio_port_checker.sv ***
// concurrent checks on the line port pins and write handshakes
`timescale 1ns/100ps
module gpio_port_checker (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	// lines and store
	input wire logic [15:0] gpio_out,
	input wire logic [15:0] gpio_oe,
	input wire logic nv_store,
	input wire logic [15:0] nv_store_dir,
	input wire logic [15:0] nv_store_rst_state,
	input wire logic nv_load
);
	logic wh, hs, cmd, isout;
	logic [3:0] op;
	// full-word write taken; a load in the same cycle wins over it
	assign wh = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign hs = wh && s_axi_wstrb == 4'hF && !nv_load;
	assign cmd = hs && s_axi_awaddr == gpio_cmd_pkg::CMD_OFFSET;
	assign op = s_axi_wdata[11:8];
	assign isout = s_axi_wdata[7:0] < 8'h10 && gpio_oe[s_axi_wdata[3:0]];
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	property p_rst; $fell(sys_rst) |-> gpio_out == 16'hFFFF && gpio_oe == 16'h0000; endproperty
	a_rst: assert property (p_rst) else $error("lines not at reset levels");
	property p_resp; wh |=> s_axi_bvalid; endproperty
	a_resp: assert property (p_resp) else $error("write not answered at once");
	property p_dir; hs && s_axi_awaddr == gpio_cmd_pkg::DIR_OFFSET |=> gpio_oe == $past(s_axi_wdata[15:0]); endproperty
	a_dir: assert property (p_dir) else $error("direction mask not applied");
	property p_high; cmd && op == 4'h1 && isout |=> gpio_out[$past(s_axi_wdata[3:0])]; endproperty
	a_high: assert property (p_high) else $error("line not driven high");
	property p_low; cmd && op == 4'h2 && isout |=> !gpio_out[$past(s_axi_wdata[3:0])]; endproperty
	a_low: assert property (p_low) else $error("line not driven low");
	property p_inkeep; cmd && (op == 4'h1 || op == 4'h2) && !isout |=> $stable(gpio_out); endproperty
	a_inkeep: assert property (p_inkeep) else $error("input line command changed outputs");
	property p_rsbad; cmd && op == 4'h3 && !isout |=> !nv_store; endproperty
	a_rsbad: assert property (p_rsbad) else $error("refused reset state was stored");
	property p_rsset;
		cmd && op == 4'h3 && isout |=> nv_store
			&& nv_store_rst_state[$past(s_axi_wdata[3:0])] == ($past(s_axi_wdata[31:16]) != 16'h0000);
	endproperty
	a_rsset: assert property (p_rsset) else $error("reset state not recorded and stored");
	property p_newout;
		hs && s_axi_awaddr == gpio_cmd_pkg::DIR_OFFSET |=>
			((gpio_out ^ nv_store_rst_state) & gpio_oe & ~$past(gpio_oe)) == 16'h0000;
	endproperty
	a_newout: assert property (p_newout) else $error("new output not at its reset state");
	property p_save; hs && s_axi_awaddr == gpio_cmd_pkg::SAVE_OFFSET |=> nv_store && nv_store_dir == gpio_oe; endproperty
	a_save: assert property (p_save) else $error("save missed the direction mask");
	// main scenarios reached
	c_rsset: cover property (cmd && op == 4'h3 && isout);
	c_inkeep: cover property (cmd && op == 4'h2 && !isout);
	c_load: cover property (nv_load);
endmodule

bind gpio_command_port gpio_port_checker u_chk (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .gpio_out, .gpio_oe, .nv_store,
	.nv_store_dir, .nv_store_rst_state, .nv_load);

// *** tb/nv_model.sv ***
// nonvolatile parameter archive on the far side of the port
`timescale 1ns/100ps
module nv_model (
	// clock
	input wire logic clk,
	// store side
	input wire logic nv_store,
	input wire logic [15:0] nv_store_dir,
	input wire logic [15:0] nv_store_rst_state,
	// load side
	input wire logic do_load,
	output logic nv_load,
	output logic [15:0] nv_load_dir,
	output logic [15:0] nv_load_rst_state,
	// archive contents
	output logic [15:0] saved_dir,
	output logic [15:0] saved_rst,
	output int stores
);
	// empty archive holds factory values
	initial begin
		saved_dir = 16'h0000;
		saved_rst = 16'hFFFF;
		stores = 0;
		nv_load = 1'b0;
	end
	// archive on each store pulse, replay on request
	always @(posedge clk) begin
		nv_load <= do_load;
		if (nv_store) begin
			saved_dir <= nv_store_dir;
			saved_rst <= nv_store_rst_state;
			stores <= stores + 1;
		end
	end
	// load data scrambled outside the pulse so stale values cannot pass
	assign nv_load_dir = nv_load ? saved_dir : ~saved_dir;
	assign nv_load_rst_state = nv_load ? saved_rst : ~saved_rst;
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the general purpose line port
`timescale 1ns/100ps
module testbench;
	logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, nv_store, nv_load, irq, do_load;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] gpio_in, gpio_out, gpio_oe, nv_store_dir, nv_store_rst_state, nv_load_dir, nv_load_rst_state;
	logic [15:0] saved_dir, saved_rst;
	int stores, checks, miscompares;
	logic [3:0] ops [4] = '{4'h2, 4'h2, 4'h1, 4'h2};
	logic [7:0] lns [4] = '{8'h03, 8'h00, 8'h03, 8'h08};
	logic [3:0] exo [4] = '{4'h7, 4'h6, 4'hE, 4'hE};
	gpio_command_port uut (.*);
	nv_model part (.*);

	// value comparison, counted
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	// verdict and end of run
	task automatic test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// bus waits are bounded; running out is a failure
	task automatic guard(input int n);
		if (n > 200) begin
			miscompares++;
			test_done();
		end
	endtask
	// one write; readies sampled where settled, released at the taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		int n;
		logic ta, tw, tb, busy;
		logic [1:0] tr;
		n = 0;
		busy = 1'b1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (busy) begin
			@(negedge clk);
			n++;
			guard(n);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			tr = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) begin
				s_axi_bready <= 1'b0;
				chk("bresp", {30'h0, er}, {30'h0, tr});
				busy = 1'b0;
			end
		end
	endtask
	// one read, data and response compared
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		int n;
		logic tv, ta;
		logic [31:0] td;
		logic [1:0] tr;
		n = 0;
		tv = 1'b0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!tv) begin
			@(negedge clk);
			n++;
			guard(n);
			ta = s_axi_arready;
			tv = s_axi_rvalid;
			td = s_axi_rdata;
			tr = s_axi_rresp;
			@(posedge clk);
			// address held up to the taking edge, released just after it
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk("rdata", e, td);
		chk("rresp", {30'h0, er}, {30'h0, tr});
	endtask

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// main sequence; pins are not judged while reset is held
	initial begin
		{sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, do_load} = 7'h40;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		gpio_in = 16'hA5A5;
		checks = 0;
		miscompares = 0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(gpio_cmd_pkg::DIR_OFFSET, 32'h00000000);
		rd(gpio_cmd_pkg::SET_ALL_OFFSET, 32'h0000FFFF);
		rd(gpio_cmd_pkg::RST_REPORT_OFFSET, 32'hFFFF0000);
		wr(gpio_cmd_pkg::DIR_OFFSET, 32'h0000000F);
		chk("oe", 32'h0000000F, {16'h0, gpio_oe});
		for (int i = 0; i < 4; i++) begin
			wr(gpio_cmd_pkg::CMD_OFFSET, {16'h0000, 4'h0, ops[i], lns[i]});
			chk("out", {28'h0, exo[i]}, {28'h0, gpio_out[3:0]});
		end
		rd(gpio_cmd_pkg::IRQ_STATUS_OFFSET, 32'h00000000);
		// error on input line, then masked and cleared
		wr(gpio_cmd_pkg::IRQ_ENABLE_OFFSET, 32'h00000001);
		wr(gpio_cmd_pkg::CMD_OFFSET, 32'h0000030F);
		rd(gpio_cmd_pkg::IRQ_STATUS_OFFSET, 32'h00000001);
		chk("irq", 32'h1, {31'h0, irq});
		wr(gpio_cmd_pkg::IRQ_ENABLE_OFFSET, 32'h00000000);
		chk("irq", 32'h0, {31'h0, irq});
		wr(gpio_cmd_pkg::IRQ_CLEAR_OFFSET, 32'h00000001);
		rd(gpio_cmd_pkg::IRQ_STATUS_OFFSET, 32'h00000000);
		// unknown opcode and out-of-range line are each refused as a command error
		wr(gpio_cmd_pkg::CMD_OFFSET, 32'h00000500);
		rd(gpio_cmd_pkg::IRQ_STATUS_OFFSET, 32'h00000001);
		wr(gpio_cmd_pkg::IRQ_CLEAR_OFFSET, 32'h00000001);
		rd(gpio_cmd_pkg::IRQ_STATUS_OFFSET, 32'h00000000);
		wr(gpio_cmd_pkg::CMD_OFFSET, 32'h00000414);
		rd(gpio_cmd_pkg::IRQ_STATUS_OFFSET, 32'h00000001);
		// reset states recorded, archived, queried and reported
		wr(gpio_cmd_pkg::CMD_OFFSET, 32'h00000302);
		wr(gpio_cmd_pkg::CMD_OFFSET, 32'h00050301);
		@(negedge clk);
		chk("stores", 32'h00000002, stores);
		chk("saved", 32'h0000FFFB, {16'h0, saved_rst});
		wr(gpio_cmd_pkg::CMD_OFFSET, 32'h00000402);
		rd(gpio_cmd_pkg::QUERY_OFFSET, 32'h00000100);
		wr(gpio_cmd_pkg::CMD_OFFSET, 32'h00000401);
		rd(gpio_cmd_pkg::QUERY_OFFSET, 32'h00000101);
		rd(gpio_cmd_pkg::RST_REPORT_OFFSET, 32'hFFF0000B);
		// former output keeps its reset state and takes it on return
		wr(gpio_cmd_pkg::DIR_OFFSET, 32'h00000000);
		wr(gpio_cmd_pkg::DIR_OFFSET, 32'h00000004);
		chk("out", 32'h0, {31'h0, gpio_out[2]});
		rd(gpio_cmd_pkg::LINE_STATE_OFFSET, 32'h0000A5A1);
		wr(gpio_cmd_pkg::SAVE_OFFSET, 32'h00000000);
		@(negedge clk);
		chk("saved", 32'h00000004, {16'h0, saved_dir});
		rd(8'h30, 32'h00000000, gpio_cmd_pkg::RESP_SLVERR);
		wr(8'h30, 32'h00000000, gpio_cmd_pkg::RESP_SLVERR);
		wr(gpio_cmd_pkg::DIR_OFFSET, 32'h0000FFFF);
		chk("out", 32'h0000FFFB, {16'h0, gpio_out});
		// archive replayed from the far side
		do_load <= 1'b1;
		@(posedge clk);
		do_load <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("oe", 32'h00000004, {16'h0, gpio_oe});
		chk("out", 32'h0, {31'h0, gpio_out[2]});
		// second reset, raised just after a rising edge like every other input
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk("out", 32'h0000FFFF, {16'h0, gpio_out});
		chk("oe", 32'h00000000, {16'h0, gpio_oe});
		rd(gpio_cmd_pkg::SET_ALL_OFFSET, 32'h0000FFFF);
		rd(gpio_cmd_pkg::DIR_OFFSET, 32'h00000000);
		rd(gpio_cmd_pkg::RST_REPORT_OFFSET, 32'hFFFF0000);
		test_done();
	end
endmodule
